// ==== logic/fts_monitor.sv ====
// Fan tachometer speed monitor channel with count and control registers
`timescale 1ns/1ps
module fts_monitor
  import fts_pkg::*;
#(
  parameter bit ODD_PIN = 1'b1
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       irq_clear,
  output logic            irq_n,
  output logic      [7:0] irq_source,
  input  wire logic [1:0] bypass_sel,
  input  wire logic       bypass_out,
  input  wire logic       gpio_oe,
  input  wire logic       gpio_out,
  input  wire logic       tach_pin_in,
  output logic            tach_pin_out,
  output logic            tach_pin_oe
);

  // ==========================================================
  // Registers and next values
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  limit_r;
  logic [7:0]  limit_nxt;
  logic [7:0]  count_r;
  logic [7:0]  count_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [11:0] ref_cnt_r;
  logic [11:0] ref_cnt_nxt;
  logic [2:0]  div_cnt_r;
  logic [2:0]  div_cnt_nxt;
  fts_rev_t    state_r;
  fts_rev_t    state_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        irq_n_r;
  logic [7:0]  irq_src_r;
  logic        pin_oe_r;
  logic        pin_oe_nxt;
  logic        pin_out_r;
  logic        pin_out_nxt;

  // ==========================================================
  // Decoded controls
  wire       en;
  wire       ien;
  wire [1:0] div_sel;
  wire [2:0] div_last;
  wire       byp_on;
  wire       wr_ctrl;
  wire       wr_limit;
  wire       rise;
  wire       ref_tick;
  wire       gate_tick;
  wire       cnt_full;
  wire       start_edge;
  wire       rev_done;
  wire       irq_hit;
  wire       clr;
  wire       publish;
  wire       restart;

  fts_tach_if tach ();

  fts_tach_filter u_filter (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin_in  (tach_pin_in),
    .tach    (tach)
  );

  assign rise = tach.tach_rise;

  // Step divider, revolution, counter, count and new interrupt hits below are gated by the enable bit; a pending interrupt holds until irq_clear
  assign en      = ctrl_r[FTS_BIT_EN];
  assign ien     = ctrl_r[FTS_BIT_IEN];
  assign div_sel = ctrl_r[FTS_DIV_MSB:FTS_DIV_LSB];
  assign div_last = fts_div_last(div_sel);
  assign byp_on  = |bypass_sel;

  assign wr_ctrl  = reg_wr && (reg_addr == FTS_ADDR_CTRL);
  assign wr_limit = reg_wr && (reg_addr == FTS_ADDR_LIMIT);

  // ==========================================================
  // Gated reference
  // One count step is divisor periods of the 20 kHz reference,
  // so count = 1,200,000 / (rpm * divisor) over one revolution
  assign ref_tick  = (ref_cnt_r == FTS_REF_LAST);
  // Greater-or-equal so a divisor lowered mid-step gates at the next reference tick
  assign gate_tick = ref_tick && (div_cnt_r >= div_last);

  assign ref_cnt_nxt = ref_tick ? FTS_REF_ZERO
                                : ref_cnt_r + FTS_REF_ONE;
  assign div_cnt_nxt = !en      ? FTS_DIV_ZERO :
                       gate_tick ? FTS_DIV_ZERO :
                       ref_tick  ? div_cnt_r + FTS_DIV_ONE :
                       div_cnt_r;

  // ==========================================================
  // Revolution tracking
  assign start_edge = en && rise && (state_r == FTS_WAIT);
  assign rev_done   = en && rise && (state_r == FTS_HALF_B);

  always_comb begin
    state_nxt = state_r;
    if (!en || clr) begin
      state_nxt = FTS_WAIT;
    end else if (rise) begin
      case (state_r)
        FTS_WAIT:   state_nxt = FTS_HALF_A;
        FTS_HALF_A: state_nxt = FTS_HALF_B;
        FTS_HALF_B: state_nxt = FTS_HALF_A;
        default:    state_nxt = FTS_WAIT;
      endcase
    end
  end

  // ==========================================================
  // Speed counter
  assign cnt_full = (cnt_r == FTS_COUNT_SAT);
  assign restart  = !en || clr || start_edge || rev_done;

  assign cnt_nxt = restart ? FTS_COUNT_ZERO :
                   (gate_tick && !cnt_full) ? cnt_r + FTS_COUNT_ONE :
                   cnt_r;

  // ==========================================================
  // Interrupt: a new hit is only seen while none is pending,
  // so a hit and a clear can never fall in the same cycle
  assign irq_hit = en && ien && !irq_r && (cnt_r >= limit_r);
  assign clr     = irq_clear && irq_r;
  assign irq_nxt = irq_hit || (irq_r && !irq_clear);

  // ==========================================================
  // Current count register
  // A stuck or stopped fan never closes a revolution, so the
  // saturated counter is published directly
  assign publish = en && !irq_r && (rev_done || cnt_full);

  assign count_nxt = (!en || clr) ? FTS_COUNT_ZERO :
                     publish      ? cnt_r :
                     count_r;

  // ==========================================================
  // Register writes
  assign ctrl_nxt  = wr_ctrl ? (reg_wdata & FTS_CTRL_WMASK) : ctrl_r;
  assign limit_nxt = wr_limit ? reg_wdata : limit_r;

  always_comb begin
    rdata_nxt = FTS_RD_NONE;
    if (reg_addr == FTS_ADDR_COUNT) begin
      rdata_nxt = count_r;
    end else if (reg_addr == FTS_ADDR_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (reg_addr == FTS_ADDR_LIMIT) begin
      rdata_nxt = limit_r;
    end else begin
      rdata_nxt = FTS_RD_NONE;
    end
  end

  // ==========================================================
  // Pin ownership: enable turns the pin into an input, but the
  // bypass select still drives an odd pin as an output
  assign pin_oe_nxt  = en ? (byp_on && ODD_PIN) : gpio_oe;
  assign pin_out_nxt = en ? bypass_out : gpio_out;

  // ==========================================================
  // State flip-flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r  <= FTS_CTRL_RST;
      limit_r <= FTS_LIMIT_RST;
      count_r <= FTS_COUNT_RST;
      cnt_r   <= FTS_COUNT_ZERO;
    end else begin
      ctrl_r  <= ctrl_nxt;
      limit_r <= limit_nxt;
      count_r <= count_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_cnt_r <= FTS_REF_ZERO;
      div_cnt_r <= FTS_DIV_ZERO;
      state_r   <= FTS_WAIT;
      irq_r     <= 1'b0;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      state_r   <= state_nxt;
      irq_r     <= irq_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r   <= FTS_RD_NONE;
      irq_n_r   <= 1'b1;
      irq_src_r <= FTS_IRQ_NONE;
      pin_oe_r  <= 1'b0;
      pin_out_r <= 1'b0;
    end else begin
      rdata_r   <= rdata_nxt;
      irq_n_r   <= !irq_nxt;
      irq_src_r <= irq_nxt ? FTS_ADDR_CTRL : FTS_IRQ_NONE;
      pin_oe_r  <= pin_oe_nxt;
      pin_out_r <= pin_out_nxt;
    end
  end

  assign reg_rdata    = rdata_r;
  assign irq_n        = irq_n_r;
  assign irq_source   = irq_src_r;
  assign tach_pin_oe  = pin_oe_r;
  assign tach_pin_out = pin_out_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_enable_rise;
    $rose(en);
  endsequence

  sequence s_second_edge;
    en && !irq_r && rise && (state_r == FTS_HALF_B);
  endsequence

  sequence s_first_edge;
    en && !clr && rise && (state_r == FTS_HALF_A);
  endsequence

  chk_count_zero_start: assert property (
    s_enable_rise |-> count_r == FTS_COUNT_ZERO)
    else $error("count not zero when monitoring starts");

  chk_rev_publish: assert property (
    s_second_edge |=> count_r == $past(cnt_r) && cnt_r == FTS_COUNT_ZERO)
    else $error("revolution count not published and restarted");

  chk_count_saturate: assert property (
    en && !irq_r && cnt_full ##1 en |-> count_r == FTS_COUNT_SAT)
    else $error("saturated count not shown as all ones");

  chk_freeze_hold: assert property (
    irq_r && !irq_clear && en ##1 en |-> $stable(count_r))
    else $error("count changed while interrupt pending");

  chk_clear_count: assert property (
    irq_r && irq_clear && en |=> count_r == FTS_COUNT_ZERO && !irq_r
      && irq_n)
    else $error("interrupt clear did not clear count");

  chk_irq_raise: assert property (
    en && ien && !irq_r && cnt_r >= limit_r |=>
      !irq_n && irq_source == FTS_ADDR_CTRL)
    else $error("interrupt not raised at limit");

  chk_pin_input: assert property (
    en && !byp_on |=> !tach_pin_oe)
    else $error("enabled tach pin still driven");

  chk_bypass_out: assert property (
    en && byp_on |=> tach_pin_oe == ODD_PIN
      && tach_pin_out == $past(bypass_out))
    else $error("bypass output lost under monitor enable");

  chk_disabled_pin: assert property (
    !en |=> tach_pin_oe == $past(gpio_oe)
      && tach_pin_out == $past(gpio_out))
    else $error("disabled monitor changed pin setup");

  chk_gated_count: assert property (
    en && !restart && !gate_tick |=> $stable(cnt_r))
    else $error("counter moved without reference tick");

  chk_two_pulses: assert property (
    s_first_edge |=> state_r == FTS_HALF_B && cnt_r >= $past(cnt_r))
    else $error("first pulse of revolution not tracked");

  chk_start_restart: assert property (
    start_edge |=> cnt_r == FTS_COUNT_ZERO)
    else $error("counter not restarted at revolution start");

  chk_count_read: assert property (
    reg_addr == FTS_ADDR_COUNT |=> reg_rdata == $past(count_r))
    else $error("count register not returned on read");

  chk_irq_quiet: assert property (
    !ien && !irq_r |=> irq_n)
    else $error("interrupt raised while disabled");

  chk_rise_level: assert property (
    rise |-> tach.tach_lvl)
    else $error("filtered rise without high level");

endmodule

// ==== pkg/fts_pkg.sv ====
// Constants, register map and types of the fan tachometer speed monitor
//
// Notes on behaviour
// - Count register shows an 8-bit read-only speed count once enabled.
// - Count reads zero until one full revolution has been measured or the counter saturates.
// - Missing or very slow tach pulses saturate the count at all ones.
// - Interrupts disabled: count register refreshes once per revolution.
// - Interrupts on: refresh per revolution until interrupt, then hold.
// - Clearing the interrupt also clears the count register to zero.
// - Enable bit makes the pin a tachometer input, overriding other setup.
// - Enable override leaves the bypass select function untouched.
// - With bypass bits set and enable on, odd-numbered tachometer pins act as outputs.
// - With enable cleared, other control bits do not affect the pin.
// - Tach pulses gate a 20 kHz reference into an 8-bit counter.
// - Two-bit divisor field selects one of four speed ranges.
// - Tach pulses are filtered so slow edges give no false counts.
// - RPM equals 1,200,000 over count times divisor.
// - Divisor codes: 00 is 1, 01 is 2, 10 is 4, 11 is 8.
// - Count at or above limit raises interrupt and reports source address.
package fts_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] FTS_ADDR_LIMIT = 8'h35;
  localparam logic [7:0] FTS_ADDR_COUNT = 8'h36;
  localparam logic [7:0] FTS_ADDR_CTRL  = 8'h38;

  localparam logic [7:0] FTS_LIMIT_RST  = 8'h00;
  localparam logic [7:0] FTS_COUNT_RST  = 8'h00;
  localparam logic [7:0] FTS_CTRL_RST   = 8'h00;
  localparam logic [7:0] FTS_CTRL_WMASK = 8'hC3;
  localparam logic [7:0] FTS_RD_NONE    = 8'h00;
  localparam logic [7:0] FTS_IRQ_NONE   = 8'h00;

  localparam logic [7:0] FTS_COUNT_ZERO = 8'h00;
  localparam logic [7:0] FTS_COUNT_ONE  = 8'h01;
  localparam logic [7:0] FTS_COUNT_SAT  = 8'hFF;

  // ==========================================================
  // Control field positions
  localparam int FTS_BIT_EN  = 7;
  localparam int FTS_BIT_IEN = 6;
  localparam int FTS_DIV_MSB = 1;
  localparam int FTS_DIV_LSB = 0;

  // ==========================================================
  // Timing
  localparam int FTS_CLK_PERIOD_NS = 25;
  localparam int FTS_REF_PERIOD_NS = 50000;
  localparam int FTS_REF_CYC  = FTS_REF_PERIOD_NS / FTS_CLK_PERIOD_NS;
  localparam logic [11:0] FTS_REF_LAST = 12'(FTS_REF_CYC - 1);
  localparam logic [11:0] FTS_REF_ZERO = 12'h000;
  localparam logic [11:0] FTS_REF_ONE  = 12'h001;
  localparam int FTS_FILT_NS  = 2000;
  localparam int FTS_FILT_CYC =
    (FTS_FILT_NS + FTS_CLK_PERIOD_NS - 1) / FTS_CLK_PERIOD_NS;
  localparam logic [7:0] FTS_FILT_LAST = 8'(FTS_FILT_CYC - 1);
  localparam logic [7:0] FTS_FILT_ZERO = 8'h00;
  localparam logic [7:0] FTS_FILT_ONE  = 8'h01;

  localparam logic [2:0] FTS_DIV_ZERO = 3'h0;
  localparam logic [2:0] FTS_DIV_ONE  = 3'h1;

  // ==========================================================
  // Types and decoders
  typedef enum logic [1:0] {
    FTS_WAIT   = 2'b00,
    FTS_HALF_A = 2'b01,
    FTS_HALF_B = 2'b10
  } fts_rev_t;

  // Last reference tick of one gated count step
  function automatic logic [2:0] fts_div_last(input logic [1:0] sel);
    logic [2:0] last;
    last = 3'h0;
    case (sel)
      2'h0: last = 3'h0;
      2'h1: last = 3'h1;
      2'h2: last = 3'h3;
      default: last = 3'h7;
    endcase
    return last;
  endfunction

endpackage

// ==== pkg/fts_tach_if.sv ====
// Filtered tachometer signals passed from the input filter to the monitor
`timescale 1ns/1ps
interface fts_tach_if;
  logic tach_lvl;
  logic tach_rise;
  modport src (output tach_lvl, output tach_rise);
  modport dst (input tach_lvl, input tach_rise);
endinterface

// ==== logic/fts_tach_filter.sv ====
// Tachometer pin synchroniser and edge filter
`timescale 1ns/1ps
module fts_tach_filter
  import fts_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  fts_tach_if.src   tach
);

  logic [2:0] sync_r;
  logic [7:0] filt_cnt_r;
  logic [7:0] filt_cnt_nxt;
  logic       lvl_r;
  logic       lvl_nxt;
  logic       rise_r;
  logic       rise_nxt;
  wire        agree;
  wire        differs;
  wire        settled;

  // ==========================================================
  // Sampling
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle-high level of the pulled-up pin: no false rise after reset
      sync_r <= 3'h7;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // ==========================================================
  // Filter: a new level must hold for the whole filter time,
  // so a slow edge wandering across the threshold is ignored
  assign agree   = (sync_r[1] == sync_r[2]);
  assign differs = agree && (sync_r[2] != lvl_r);
  assign settled = differs && (filt_cnt_r == FTS_FILT_LAST);

  assign filt_cnt_nxt = !differs ? FTS_FILT_ZERO :
                        settled  ? FTS_FILT_ZERO :
                        filt_cnt_r + FTS_FILT_ONE;
  assign lvl_nxt  = settled ? sync_r[2] : lvl_r;
  assign rise_nxt = settled && sync_r[2];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_cnt_r <= FTS_FILT_ZERO;
      lvl_r      <= 1'b1;
      rise_r     <= 1'b0;
    end else begin
      filt_cnt_r <= filt_cnt_nxt;
      lvl_r      <= lvl_nxt;
      rise_r     <= rise_nxt;
    end
  end

  assign tach.tach_lvl  = lvl_r;
  assign tach.tach_rise = rise_r;

  // ==========================================================
  // Checks
  chk_filter_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rise_r |-> $past(filt_cnt_r, 2) == FTS_FILT_LAST - FTS_FILT_ONE)
    else $error("tach edge passed without full filter time");

endmodule

// ==== verification/fts_fan_model.sv ====
// Behavioural fan tachometer: two pulses per revolution, idle high
`timescale 1ns/1ps
module fts_fan_model
(
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic [15:0] half_cyc,
  input  wire logic        bounce,
  output logic             tach
);
  // ==========================================================
  // Pulse generator
  logic [15:0] ph_r;
  logic [15:0] mid;
  logic        dip;

  // Short contact bounce in the middle of the high phase
  assign mid = half_cyc >> 1;
  assign dip = bounce & (ph_r >= mid) & (ph_r < mid + 16'h0008);

  always_ff @(posedge ref_clk) begin
    if (!run) begin
      ph_r <= 16'h0000;
      // Pull-up holds a stopped tach output high
      tach <= 1'b1;
    end else begin
      // Wrap also when the period is shortened in mid-pulse
      ph_r <= (ph_r >= (half_cyc << 1) - 16'h0001) ? 16'h0000
                                                    : ph_r + 16'h0001;
      tach <= (ph_r < half_cyc) & ~dip;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking testbench of the fan tachometer speed monitor
`timescale 1ns/1ps
module tb_top import fts_pkg::*;;
  // ==========================================================
  // Signals
  logic        ref_clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        irq_clear;
  logic        irq_n;
  logic [7:0]  irq_source;
  logic [1:0]  bypass_sel;
  logic        bypass_out;
  logic        gpio_oe;
  logic        gpio_out;
  logic        tach_line;
  logic        tach_pin_out;
  logic        tach_pin_oe;
  logic        fan_run;
  logic [15:0] fan_half;
  logic        fan_bounce;
  logic        fan_tach;
  logic [7:0]  rv;
  logic [7:0]  held;
  int          num_errors;
  int          num_checks;
  int          i;

  // Fan revolution of 8000 cycles: two pulses of 4000 cycles
  localparam int REV = 8000;

  always #12.5 ref_clk = ~ref_clk;

  // Pin level: the device wins while it drives, else the fan
  assign tach_line = tach_pin_oe ? tach_pin_out : fan_tach;

  fts_monitor dut (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .reg_addr     (reg_addr),
    .reg_wr       (reg_wr),
    .reg_wdata    (reg_wdata),
    .reg_rdata    (reg_rdata),
    .irq_clear    (irq_clear),
    .irq_n        (irq_n),
    .irq_source   (irq_source),
    .bypass_sel   (bypass_sel),
    .bypass_out   (bypass_out),
    .gpio_oe      (gpio_oe),
    .gpio_out     (gpio_out),
    .tach_pin_in  (tach_line),
    .tach_pin_out (tach_pin_out),
    .tach_pin_oe  (tach_pin_oe)
  );

  fts_fan_model fan (
    .ref_clk  (ref_clk),
    .run      (fan_run),
    .half_cyc (fan_half),
    .bounce   (fan_bounce),
    .tach     (fan_tach)
  );

  // ==========================================================
  // Access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    reg_addr = a;
    tick(1);
    d = reg_rdata;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp(d, exp);
  endtask

  // A count within one count step of revolution time over step
  task automatic cnt_ok(input logic [7:0] got, input int div);
    int span;
    span = FTS_REF_CYC * div;
    num_checks++;
    if ($isunknown(got) || got * span > REV + span
        || got * span + span < REV) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, REV / span);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    irq_clear = 1'b0;
    bypass_sel = 2'h0;
    bypass_out = 1'b0;
    gpio_oe = 1'b0;
    gpio_out = 1'b0;
    fan_run = 1'b0;
    fan_half = 16'h07D0;
    fan_bounce = 1'b0;
    num_errors = 0;
    num_checks = 0;
    tick(12);
    reset_n = 1'b1;

    cmp(irq_n, 1'b1);
    rd_cmp(FTS_ADDR_COUNT, FTS_COUNT_RST);
    rd_cmp(FTS_ADDR_CTRL, FTS_CTRL_RST);
    rd_cmp(FTS_ADDR_LIMIT, FTS_LIMIT_RST);
    wr(FTS_ADDR_COUNT, 8'h5A);
    rd_cmp(FTS_ADDR_COUNT, FTS_COUNT_ZERO);
    wr(8'h37, 8'hFF);
    rd_cmp(8'h37, FTS_RD_NONE);
    wr(FTS_ADDR_CTRL, 8'h7F);
    rd_cmp(FTS_ADDR_CTRL, 8'h43);
    $display("test registers done");

    gpio_oe = 1'b1;
    gpio_out = 1'b1;
    bypass_sel = 2'h3;
    tick(2);
    cmp(tach_pin_oe, 1'b1);
    cmp(tach_pin_out, 1'b1);
    gpio_out = 1'b0;
    tick(2);
    cmp(tach_pin_out, 1'b0);
    wr(FTS_ADDR_CTRL, 8'h80);
    bypass_sel = 2'h0;
    gpio_out = 1'b1;
    tick(2);
    cmp(tach_pin_oe, 1'b0);
    bypass_sel = 2'h2;
    bypass_out = 1'b1;
    gpio_out = 1'b0;
    tick(2);
    cmp(tach_pin_oe, 1'b1);
    cmp(tach_pin_out, 1'b1);
    bypass_sel = 2'h1;
    bypass_out = 1'b0;
    tick(2);
    cmp(tach_pin_out, 1'b0);
    bypass_sel = 2'h0;
    gpio_oe = 1'b0;
    tick(2);
    $display("test pin override done");

    fan_run = 1'b1;
    tick(100);
    rd_cmp(FTS_ADDR_COUNT, FTS_COUNT_ZERO);
    for (i = 0; i < 4; i++) begin
      wr(FTS_ADDR_CTRL, 8'h80 | 8'(i));
      tick(16200);
      rd(FTS_ADDR_COUNT, rv);
      cnt_ok(rv, 1 << i);
    end
    fan_bounce = 1'b1;
    wr(FTS_ADDR_CTRL, 8'h80);
    tick(16200);
    rd(FTS_ADDR_COUNT, rv);
    cnt_ok(rv, 1);
    fan_bounce = 1'b0;
    cmp(irq_n, 1'b1);
    $display("test polled counts done");

    wr(FTS_ADDR_LIMIT, 8'h03);
    rd_cmp(FTS_ADDR_LIMIT, 8'h03);
    wr(FTS_ADDR_CTRL, 8'hC0);
    for (i = 0; i < 20000 && irq_n !== 1'b0; i++) tick(1);
    if (irq_n !== 1'b0) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, irq_n, 1'b0);
    end else begin
      cmp(irq_source, FTS_ADDR_CTRL);
      rd(FTS_ADDR_COUNT, held);
      // A faster fan would publish a smaller count unless frozen
      fan_half = 16'h03E8;
      tick(9000);
      rd_cmp(FTS_ADDR_COUNT, held);
      cmp(irq_n, 1'b0);
      irq_clear = 1'b1;
      tick(1);
      irq_clear = 1'b0;
      cmp(irq_n, 1'b1);
      rd_cmp(FTS_ADDR_COUNT, FTS_COUNT_ZERO);
    end
    $display("test interrupt mode done");
    stop_test();
  end
endmodule
